// ==== hdl/csr_defs.svh ====
// Purpose: constants shared by both ends of the status readout link
// Assumes: status word and host register file are 32 bits wide
// Notes:   offsets are byte addresses on the host command port
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH

`define IR_WIDTH        8
`define DR_WIDTH        32
`define INSTR_STATUS    8'h41
`define INSTR_IDCODE    8'h11
`define IR_CAPTURE_VAL  8'h01
`define STATUS_RESET    32'h0000_0000
`define IDCODE_DEFAULT  32'h0000_0001

`define BIT_CRC_ERR     0
`define BIT_CMD_ERR     1
`define BIT_ID_ERR      2
`define BIT_TMO_ERR     3
`define BIT_ERASE       5
`define BIT_PREAMBLE    6
`define BIT_EDIT        7
`define BIT_SPI_PASS    8
`define BIT_SELF_LOAD   9
`define BIT_NON_SCAN    10
`define BIT_BYPASS      11
`define BIT_EF_VALID    12
`define BIT_DONE        13
`define BIT_SECURE      14
`define BIT_READY       15
`define BIT_POR         16
`define BIT_LOCK        17

`define OK_MASK_FLASH   32'h0001_B000
`define OK_MASK_ENC     32'h0000_2000
`define ERR_FIELD_MASK  32'h0000_000F

`define REG_CTRL        4'h0
`define REG_STAT        4'h4
`define REG_WORD        4'h8
`define CTRL_START      0
`define STAT_BUSY       0
`define STAT_DONE       1
`define STAT_OK         2

`define MCLK_PERIOD_NS  4
`define TCK_PERIOD_NS   80
`define TCK_HALF_CYC    ((`TCK_PERIOD_NS / 2) / `MCLK_PERIOD_NS)

`define STEP_IR_FIRST   6'd10
`define STEP_IR_LAST    6'd17
`define STEP_DR_FIRST   6'd22
`define STEP_DR_LAST    6'd53
`define STEP_LAST       6'd55

`endif

// ==== hdl/csr_pkg.sv ====
// Purpose: types shared by both ends
// Assumes: nothing beyond the defs header
// Notes:   scan states follow the usual sixteen-state test port walk
package csr_pkg;

    typedef enum logic [1:0] {
        VAR_BASIC = 2'b00,
        VAR_BOOT  = 2'b01,
        VAR_ENC   = 2'b10
    } variant_t;

    typedef enum logic [3:0] {
        TS_RESET  = 4'b0000, TS_IDLE   = 4'b0001,
        TS_SELDR  = 4'b0010, TS_CAPDR  = 4'b0011,
        TS_SHDR   = 4'b0100, TS_EX1DR  = 4'b0101,
        TS_PAUDR  = 4'b0110, TS_EX2DR  = 4'b0111,
        TS_UPDR   = 4'b1000, TS_SELIR  = 4'b1001,
        TS_CAPIR  = 4'b1010, TS_SHIR   = 4'b1011,
        TS_EX1IR  = 4'b1100, TS_PAUIR  = 4'b1101,
        TS_EX2IR  = 4'b1110, TS_UPIR   = 4'b1111
    } tap_state_t;

    typedef enum logic [0:0] {
        HS_IDLE = 1'b0,
        HS_RUN  = 1'b1
    } host_state_t;

endpackage : csr_pkg

// ==== hdl/scan_link_if.sv ====
// Purpose: four-wire test port between host and device
// Assumes: host makes the test clock
// Notes:   tdo is always driven; tdo_en is high while it carries shifted bits
`timescale 1ns/10ps
`default_nettype none
interface scan_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_en;

    modport device (input tck, input tms, input tdi, output tdo, output tdo_en);
    modport host (output tck, output tms, output tdi, input tdo, input tdo_en);
endinterface : scan_link_if
`default_nettype wire

// ==== hdl/tap_walker.sv ====
// Purpose: test port state walk, advanced once per test clock rise
// Assumes: tms already synchronised to mclk
// Notes:   five rises with tms high reach reset from anywhere
`timescale 1ns/10ps
`default_nettype none
module tap_walker (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // walk control
    input  wire logic              adv,
    input  wire logic              tms,
    // state
    output var csr_pkg::tap_state_t state
);
    import csr_pkg::*;

    tap_state_t state_next;

    always_comb begin
        case (state)
            TS_RESET: state_next = tms ? TS_RESET : TS_IDLE;
            TS_IDLE:  state_next = tms ? TS_SELDR : TS_IDLE;
            TS_SELDR: state_next = tms ? TS_SELIR : TS_CAPDR;
            TS_CAPDR: state_next = tms ? TS_EX1DR : TS_SHDR;
            TS_SHDR:  state_next = tms ? TS_EX1DR : TS_SHDR;
            TS_EX1DR: state_next = tms ? TS_UPDR  : TS_PAUDR;
            TS_PAUDR: state_next = tms ? TS_EX2DR : TS_PAUDR;
            TS_EX2DR: state_next = tms ? TS_UPDR  : TS_SHDR;
            TS_UPDR:  state_next = tms ? TS_SELDR : TS_IDLE;
            TS_SELIR: state_next = tms ? TS_RESET : TS_CAPIR;
            TS_CAPIR: state_next = tms ? TS_EX1IR : TS_SHIR;
            TS_SHIR:  state_next = tms ? TS_EX1IR : TS_SHIR;
            TS_EX1IR: state_next = tms ? TS_UPIR  : TS_PAUIR;
            TS_PAUIR: state_next = tms ? TS_EX2IR : TS_PAUIR;
            TS_EX2IR: state_next = tms ? TS_UPIR  : TS_SHIR;
            TS_UPIR:  state_next = tms ? TS_SELDR : TS_IDLE;
            default:  state_next = TS_RESET;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= TS_RESET;
        end else if (adv) begin
            state <= state_next;
        end
    end
endmodule : tap_walker
`default_nettype wire

// ==== hdl/status_device.sv ====
// Purpose: device end, serves the configuration status word on the test port
// Assumes: engine inputs are levels or pulses on mclk; tck far below mclk/8
// Notes:   link pins are sampled by mclk, tck edges found after two flops
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"

// How it works
// - instruction 0x41 selects the 32-bit status word
// - readout walk identical to identification read
// - bit 0 flags checksum error
// - bit 1 flags illegal command
// - bit 2 flags identification mismatch
// - bit 3 flags configuration timeout
// - bit 12 is embedded flash validity
// - bit 12 reads zero without embedded flash
// - bit 13 set after successful load
// - bit 14 reports readback protection setting
// - bit 15 is ready in plain variants
// - bit 16 is wake-up success in plain variants
// - encrypting variant bit 15 reports encrypted stream
// - encrypting variant bit 16 reports key match
// - ready drops on a programming fault or while wake-up success is low
// - host reads bits 3..0 when ready low
// - host qualifies completion with ready in plain variants
// - encryption bits cleared once programming ends
// - host success needs wake-up, ready, done, valid in plain variants; done in encrypting; a clear bits 3..0 in all
module status_device #(
    parameter csr_pkg::variant_t VARIANT    = csr_pkg::VAR_BASIC,
    parameter logic [7:0]        ID_INSTR   = `INSTR_IDCODE,
    parameter logic [31:0]       IDCODE_VAL = `IDCODE_DEFAULT
) (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst,
    // test port
    scan_link_if.device link,
    // configuration engine: start and error events, one-cycle pulses
    input  wire logic   cfg_start,
    input  wire logic   crc_err,
    input  wire logic   cmd_err,
    input  wire logic   id_err,
    input  wire logic   tmo_err,
    // configuration engine: levels
    input  wire logic   por_ok,
    input  wire logic   load_done,
    input  wire logic   secure_on,
    input  wire logic   prog_active,
    input  wire logic   enc_format,
    input  wire logic   key_match,
    input  wire logic   embedded_flash_valid,
    input  wire logic   self_load_state,
    input  wire logic   flash_lock,
    input  wire logic   mem_erase,
    input  wire logic   preamble_seen,
    input  wire logic   edit_mode,
    input  wire logic   spi_passthru,
    input  wire logic   non_scan_active,
    input  wire logic   bypass_state,
    // status word as served
    output logic [31:0] status_word
);
    import csr_pkg::*;

    localparam int NPIN = 3;

    logic [NPIN-1:0]      pin_in;
    logic [NPIN-1:0]      pin_meta;
    logic [NPIN-1:0]      pin_sync;
    logic                 tck_prev;
    logic                 tck_rise;
    logic                 tck_fall;
    logic                 tms_s;
    logic                 tdi_s;
    tap_state_t           tap_state;
    logic [`IR_WIDTH-1:0] ir_sr;
    logic [`IR_WIDTH-1:0] ir_reg;
    logic [`DR_WIDTH-1:0] dr_sr;
    logic [3:0]           err_reg;
    logic [31:0]          status_reg;
    logic [31:0]          status_next;
    logic                 any_err;
    logic                 ready;
    logic                 tdo_reg;
    logic                 tdo_en_reg;

    assign pin_in = {link.tck, link.tms, link.tdi};

    // pins come from another domain; second flop is the only reader
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (rst) begin
                    pin_meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end else begin
                    pin_meta[i] <= pin_in[i];
                    pin_sync[i] <= pin_meta[i];
                end
            end
        end
    endgenerate

    assign tms_s = pin_sync[1];
    assign tdi_s = pin_sync[0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= pin_sync[2];
        end
    end

    assign tck_rise = pin_sync[2] & ~tck_prev;
    assign tck_fall = ~pin_sync[2] & tck_prev;

    tap_walker u_walk (
        .mclk  (mclk),
        .rst   (rst),
        .adv   (tck_rise),
        .tms   (tms_s),
        .state (tap_state)
    );

    // sticky faults; a fault in the same cycle as a restart is kept
    always_ff @(posedge mclk) begin
        if (rst) begin
            err_reg <= 4'h0;
        end else begin
            err_reg <= (cfg_start ? 4'h0 : err_reg)
                     | {tmo_err, id_err, cmd_err, crc_err};
        end
    end

    assign any_err = |err_reg;
    assign ready   = por_ok & ~any_err;

    always_comb begin
        status_next                 = `STATUS_RESET;
        status_next[`BIT_CRC_ERR]   = err_reg[0];
        status_next[`BIT_CMD_ERR]   = err_reg[1];
        status_next[`BIT_ID_ERR]    = err_reg[2];
        status_next[`BIT_TMO_ERR]   = err_reg[3];
        status_next[`BIT_ERASE]     = mem_erase;
        status_next[`BIT_PREAMBLE]  = preamble_seen;
        status_next[`BIT_EDIT]      = edit_mode;
        status_next[`BIT_SPI_PASS]  = spi_passthru;
        status_next[`BIT_NON_SCAN]  = non_scan_active;
        status_next[`BIT_BYPASS]    = bypass_state;
        status_next[`BIT_DONE]      = load_done & ~any_err;
        status_next[`BIT_SECURE]    = secure_on;
        if (VARIANT == VAR_BOOT) begin
            status_next[`BIT_SELF_LOAD] = self_load_state;
            status_next[`BIT_LOCK]      = flash_lock;
        end
        if (VARIANT == VAR_ENC) begin
            // only meaningful mid-programming, so gated by activity
            status_next[`BIT_READY] = enc_format & prog_active;
            status_next[`BIT_POR]   = key_match & prog_active;
        end else begin
            status_next[`BIT_EF_VALID] = embedded_flash_valid;
            status_next[`BIT_READY]    = ready;
            status_next[`BIT_POR]      = por_ok;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_reg <= `STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status_word = status_reg;

    // instruction path
    always_ff @(posedge mclk) begin
        if (rst) begin
            ir_sr  <= `IR_CAPTURE_VAL;
            ir_reg <= ID_INSTR;
        end else if (tck_rise) begin
            case (tap_state)
                TS_RESET: begin
                    ir_reg <= ID_INSTR;
                end
                TS_CAPIR: begin
                    ir_sr <= `IR_CAPTURE_VAL;
                end
                TS_SHIR: begin
                    ir_sr <= {tdi_s, ir_sr[`IR_WIDTH-1:1]};
                end
                TS_UPIR: begin
                    ir_reg <= ir_sr;
                end
                default: begin
                    ir_reg <= ir_reg;
                end
            endcase
        end
    end

    // data path: status and id share capture and shift timing
    always_ff @(posedge mclk) begin
        if (rst) begin
            dr_sr <= `STATUS_RESET;
        end else if (tck_rise) begin
            case (tap_state)
                TS_CAPDR: begin
                    if (ir_reg == `INSTR_STATUS) begin
                        dr_sr <= status_reg;
                    end else if (ir_reg == ID_INSTR) begin
                        dr_sr <= IDCODE_VAL;
                    end else begin
                        dr_sr <= `STATUS_RESET;
                    end
                end
                TS_SHDR: begin
                    if (ir_reg == `INSTR_STATUS || ir_reg == ID_INSTR) begin
                        dr_sr <= {tdi_s, dr_sr[`DR_WIDTH-1:1]};
                    end else begin
                        dr_sr[0] <= tdi_s;
                    end
                end
                default: begin
                    dr_sr <= dr_sr;
                end
            endcase
        end
    end

    // output moves on the falling test clock so host samples it settled
    always_ff @(posedge mclk) begin
        if (rst) begin
            tdo_reg    <= 1'b0;
            tdo_en_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg    <= (tap_state == TS_SHIR) ? ir_sr[0] : dr_sr[0];
            tdo_en_reg <= (tap_state == TS_SHIR) || (tap_state == TS_SHDR);
        end
    end

    assign link.tdo    = tdo_reg;
    assign link.tdo_en = tdo_en_reg;
endmodule : status_device
`default_nettype wire

// ==== hdl/status_host.sv ====
// Purpose: host end, reads the device status word over the test port
// Assumes: software drives the plain command port
// Notes:   test clock made by dividing mclk; one fixed walk per start
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"
module status_host #(
    parameter csr_pkg::variant_t VARIANT = csr_pkg::VAR_BASIC,
    parameter int                HALF    = `TCK_HALF_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // command port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // test port
    scan_link_if.host        link
);
    import csr_pkg::*;

    host_state_t        hstate;
    logic [15:0]        div_cnt;
    logic               tck_reg;
    logic               tms_reg;
    logic               tdi_reg;
    logic [5:0]         step;
    logic               tdo_meta;
    logic               tdo_sync;
    logic [31:0]        word_sr;
    logic [31:0]        word_reg;
    logic               done_reg;
    logic               ok;
    logic [31:0]        ok_mask;
    logic               start;
    logic               div_wrap;

    // pin levels for each step of the fixed walk; bit1 tms, bit0 tdi
    function automatic logic [1:0] step_pins(input logic [5:0] s);
        logic [7:0] ir;
        ir = `INSTR_STATUS;
        step_pins = 2'b00;
        if (s < 6'd5 || s == 6'd6 || s == 6'd7 || s == 6'd18 ||
            s == 6'd19 || s == 6'd54) begin
            step_pins = 2'b10;
        end else if (s >= `STEP_IR_FIRST && s <= `STEP_IR_LAST) begin
            step_pins = {s == `STEP_IR_LAST, ir[3'(s - `STEP_IR_FIRST)]};
        end else if (s >= `STEP_DR_FIRST && s <= `STEP_DR_LAST) begin
            step_pins = {s == `STEP_DR_LAST, 1'b0};
        end
    endfunction : step_pins

    assign start    = wr && addr == `REG_CTRL && wdata[`CTRL_START] && hstate == HS_IDLE;
    assign div_wrap = div_cnt == 16'(HALF - 1);

    always_ff @(posedge mclk) begin
        if (rst) begin
            tdo_meta <= 1'b0;
            tdo_sync <= 1'b0;
        end else begin
            tdo_meta <= link.tdo;
            tdo_sync <= tdo_meta;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hstate   <= HS_IDLE;
            div_cnt  <= 16'h0000;
            tck_reg  <= 1'b0;
            tms_reg  <= 1'b1;
            tdi_reg  <= 1'b0;
            step     <= 6'h00;
            word_sr  <= `STATUS_RESET;
            word_reg <= `STATUS_RESET;
            done_reg <= 1'b0;
        end else begin
            case (hstate)
                HS_IDLE: begin
                    if (start) begin
                        hstate   <= HS_RUN;
                        div_cnt  <= 16'h0000;
                        step     <= 6'h00;
                        done_reg <= 1'b0;
                        {tms_reg, tdi_reg} <= step_pins(6'h00);
                    end
                end
                HS_RUN: begin
                    div_cnt <= div_wrap ? 16'h0000 : div_cnt + 16'h0001;
                    if (div_wrap && !tck_reg) begin
                        tck_reg <= 1'b1;
                        if (step >= `STEP_DR_FIRST && step <= `STEP_DR_LAST) begin
                            word_sr <= {tdo_sync, word_sr[31:1]};
                        end
                    end else if (div_wrap) begin
                        tck_reg <= 1'b0;
                        if (step == `STEP_LAST) begin
                            hstate   <= HS_IDLE;
                            word_reg <= word_sr;
                            done_reg <= 1'b1;
                        end else begin
                            step <= step + 6'h01;
                            {tms_reg, tdi_reg} <= step_pins(step + 6'h01);
                        end
                    end
                end
                default: begin
                    hstate <= HS_IDLE;
                end
            endcase
        end
    end

    // done alone is not success: error field, and ready outside the encrypting variant, qualify it
    assign ok_mask = (VARIANT == VAR_ENC) ? `OK_MASK_ENC : `OK_MASK_FLASH;
    assign ok = done_reg && ((word_reg & ok_mask) == ok_mask)
             && ((word_reg & `ERR_FIELD_MASK) == 32'h0000_0000);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                `REG_STAT: rdata <= {29'h0, ok, done_reg, hstate == HS_RUN};
                `REG_WORD: rdata <= word_reg;
                default:   rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    assign link.tck = tck_reg;
    assign link.tms = tms_reg;
    assign link.tdi = tdi_reg;
endmodule : status_host
`default_nettype wire

// ==== test/status_link_properties.sv ====
// Purpose: link checks beside the host to device test port
// Assumes: host built with HALF of 8, device captures at the usual capture states
// Notes:   step counts tck rises since the link last sat idle for 40 mclk
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"
module status_link_properties (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // link
    input wire logic        tck,
    input wire logic        tms,
    input wire logic        tdi,
    input wire logic        tdo,
    input wire logic        tdo_en,
    // word served by the device
    input wire logic [31:0] status_word,
    // other variants on the shared walk
    input wire logic [1:0]  peer_tdo,
    input wire logic [1:0]  peer_tdo_en
);
    logic [6:0] step_reg;
    logic [5:0] idle_reg;
    logic       tck_d_reg;
    logic [7:0] ir_code;
    logic [7:0] ir_cap;
    logic       in_shift;
    assign ir_code = `INSTR_STATUS;
    assign ir_cap = `IR_CAPTURE_VAL;
    assign in_shift = (step_reg >= 7'd10 && step_reg <= 7'd17)
                   || (step_reg >= 7'd22 && step_reg <= 7'd53);

    function automatic logic tms_exp(input logic [6:0] s);
        return s < 7'd5 || s == 7'd6 || s == 7'd7 || (s >= 7'd17 && s <= 7'd19)
            || s == 7'd53 || s == 7'd54;
    endfunction : tms_exp

    always_ff @(posedge mclk) begin
        tck_d_reg <= rst ? 1'b0 : tck;
    end
    always_ff @(posedge mclk) begin
        if (rst || tck) begin
            idle_reg <= 6'h0;
        end else if (idle_reg != 6'h3F) begin
            idle_reg <= idle_reg + 6'h1;
        end
    end
    // a long quiet link means the next rise opens a new walk
    always_ff @(posedge mclk) begin
        if (rst || idle_reg == 6'd40) begin
            step_reg <= 7'h0;
        end else if (tck && !tck_d_reg) begin
            step_reg <= step_reg + 7'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    tck_high_a: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
        else $error("tck high half not eight cycles");
    tck_low_a: assert property ($fell(tck) |-> !tck [*8])
        else $error("tck low half too short");
    host_hold_a: assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
        else $error("tms or tdi moved while tck high");
    tms_walk_a: assert property ($rose(tck) |-> tms == tms_exp(step_reg))
        else $error("tms off the readout walk");
    instr_code_a: assert property ($rose(tck) && step_reg >= 7'd10 && step_reg <= 7'd17
        |-> tdi == ir_code[step_reg[2:0] - 3'd2])
        else $error("instruction bit shifted wrong");
    drive_window_a: assert property ($rose(tck) |-> tdo_en == in_shift)
        else $error("tdo driven outside shift");
    ir_capture_a: assert property ($rose(tck) && step_reg >= 7'd10 && step_reg <= 7'd17
        |-> tdo == ir_cap[step_reg[2:0] - 3'd2])
        else $error("instruction capture bit wrong");
    word_out_a: assert property ($rose(tck) && step_reg >= 7'd22 && step_reg <= 7'd53
        |-> tdo == status_word[step_reg[4:0] - 5'd22])
        else $error("status bit on tdo wrong");
    walk_len_a: assert property ($rose(tck) |-> step_reg < 7'd56)
        else $error("walk longer than 56 steps");
    tdo_hold_a: assert property (tck && $past(tck) |-> $stable(tdo))
        else $error("tdo moved while tck high");
    peer_window_a: assert property (peer_tdo_en == {2{tdo_en}})
        else $error("variant drives tdo outside shared window");
    peer_capture_a: assert property ($rose(tck) && in_shift && step_reg < 7'd18
        |-> peer_tdo == {2{tdo}})
        else $error("variant instruction capture differs");

    cover property ($rose(tck) && step_reg == 7'd55);
    cover property ($rose(tck) && step_reg == 7'd22 && tdo);
    cover property ($rose(tck) && step_reg == 7'd37 && !tdo);
endmodule : status_link_properties
`default_nettype wire

// ==== test/config_status_register_readout_tb.sv ====
// Purpose: bench for three device variants and the host reader
// Assumes: host uses HALF of 8; variant boot sits on the checked link
// Notes:   other variants share the host's tck, tms and tdi
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"
module config_status_register_readout_tb;
    import csr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        cfg_start = 1'b0;
    logic [3:0]  err = 4'h0;
    logic [14:0] lv = 15'h0;
    logic [3:0]  sticky = 4'h0;
    logic [31:0] sw [3];
    int          num_errors = 0;
    int          n_compared = 0;
    int          seed = 32'h4426C5CD;
    int          cyc = 0;
    scan_link_if lnks [3] ();

    initial begin
        forever #2 mclk = ~mclk;
    end

    for (genvar g = 0; g < 3; g++) begin : dev
        if (g != 1) begin : tie
            assign lnks[g].tck = lnks[1].tck;
            assign lnks[g].tms = lnks[1].tms;
            assign lnks[g].tdi = lnks[1].tdi;
        end
        status_device #(.VARIANT(variant_t'(g))) status_device_inst (
            .mclk(mclk), .rst(rst), .link(lnks[g]), .cfg_start(cfg_start),
            .crc_err(err[0]), .cmd_err(err[1]), .id_err(err[2]), .tmo_err(err[3]),
            .por_ok(lv[0]), .load_done(lv[1]), .secure_on(lv[2]), .prog_active(lv[3]),
            .enc_format(lv[4]), .key_match(lv[5]), .embedded_flash_valid(lv[6]),
            .self_load_state(lv[7]), .flash_lock(lv[8]), .mem_erase(lv[9]),
            .preamble_seen(lv[10]), .edit_mode(lv[11]), .spi_passthru(lv[12]),
            .non_scan_active(lv[13]), .bypass_state(lv[14]), .status_word(sw[g]));
    end
    status_host #(.VARIANT(VAR_BOOT), .HALF(8)) status_host_inst (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(lnks[1]));
    status_link_properties status_link_properties_inst (
        .mclk(mclk), .rst(rst), .tck(lnks[1].tck), .tms(lnks[1].tms), .tdi(lnks[1].tdi),
        .tdo(lnks[1].tdo), .tdo_en(lnks[1].tdo_en), .status_word(sw[1]),
        .peer_tdo({lnks[2].tdo, lnks[0].tdo}), .peer_tdo_en({lnks[2].tdo_en, lnks[0].tdo_en}));

    function automatic logic [31:0] exp_word(input variant_t v, input logic [14:0] l,
                                             input logic [3:0] e);
        logic [31:0] w;
        logic        enc;
        enc = (v == VAR_ENC);
        w = 32'h0;
        w[3:0] = e;
        w[8:5] = l[12:9];
        w[11:10] = l[14:13];
        w[9] = (v == VAR_BOOT) & l[7];
        w[17] = (v == VAR_BOOT) & l[8];
        w[12] = ~enc & l[6];
        w[13] = l[1] & (e == 4'h0);
        w[14] = l[2];
        // encryption flags only mean something while programming runs
        w[15] = enc ? (l[4] & l[3]) : (l[0] & (e == 4'h0));
        w[16] = enc ? (l[5] & l[3]) : l[0];
        return w;
    endfunction : exp_word

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic pulse(input logic cs, input logic [3:0] e);
        @(posedge mclk);
        cfg_start <= cs;
        err <= e;
        @(posedge mclk);
        cfg_start <= 1'b0;
        err <= 4'h0;
        sticky = (cs ? 4'h0 : sticky) | e;
    endtask : pulse

    task automatic check_words();
        logic [31:0] w;
        repeat (3) @(posedge mclk);
        #1;
        for (int g = 0; g < 3; g++) begin
            w = exp_word(variant_t'(g), lv, sticky);
            chk(sw[g] & `ERR_FIELD_MASK, w & `ERR_FIELD_MASK);
            chk(sw[g] & 32'h0000_7000, w & 32'h0000_7000);
            chk(sw[g] & 32'h0001_8000, w & 32'h0001_8000);
            chk(sw[g], w);
        end
    endtask : check_words

    task automatic walk();
        logic [31:0] d;
        logic [31:0] w;
        logic        ok;
        int          n;
        repeat (48) @(posedge mclk);
        w = exp_word(VAR_BOOT, lv, sticky);
        ok = ((w & `OK_MASK_FLASH) == `OK_MASK_FLASH) && (w[3:0] == 4'h0);
        wr_reg(`REG_CTRL, 32'h1);
        n = 0;
        d = 32'h0;
        while (d[`STAT_DONE] !== 1'b1 && n < 2000) begin
            rd_reg(`REG_STAT, d);
            n++;
        end
        chk({29'h0, d[2:0]}, {29'h0, ok, 2'b10});
        rd_reg(`REG_WORD, d);
        chk(d, w);
        rd_reg(4'hC, d);
        chk(d, 32'h0);
    endtask : walk

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        check_words();
        lv <= 15'h7FFF;
        check_words();
        walk();
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            lv <= 15'($random(seed));
            pulse((i == 4) || (($random(seed) & 7) == 0),
                  (i < 5) ? (4'h1 << (i % 4)) : ((i % 3 == 0) ? 4'($random(seed)) : 4'h0));
            check_words();
            if (i % 4 == 0) begin
                walk();
            end
        end
        tally_and_finish();
    end
endmodule : config_status_register_readout_tb
`default_nettype wire
